// ---- rtl/imem_pkg.sv ----
// Shared constants and types for the internal memory block interface.
// Assumes four single-ported blocks of four 16-bit columns each.
package imem_pkg;
  localparam int BLOCKS    = 4;
  localparam int COLS      = 4;
  localparam int REQS      = 4;
  localparam int COL_W     = 16;
  localparam int ROW_AW    = 16;
  localparam int ADDR_W    = 18;
  localparam int DATA_W    = 64;
  localparam int LANE_W    = 2;
  localparam int BLK_W     = 2;
  localparam int TRI_COLS  = 3;
  localparam int NW_BITS   = 32;
  localparam int EXT_BITS  = 40;
  localparam int FETCH_W   = 48;
  localparam int WB_DEPTH  = 2;
  localparam logic [7:0] EXT_PAD = 8'h00;
  // Requester index doubles as priority, lowest wins
  localparam int IO_BUS_PRIMARY      = 0;
  localparam int IO_BUS_SECONDARY    = 1;
  localparam int DATA_MEMORY_BUS     = 2;
  localparam int PROGRAM_MEMORY_BUS  = 3;
  typedef enum logic [1:0] {
    SHORT_WORD_ACCESS,
    NORMAL_WORD_ACCESS,
    LONG_WORD_ACCESS,
    INSTR_FETCH
  } access_kind_e;
  typedef struct packed {
    logic [COLS-1:0]              en;
    logic [COLS-1:0][ROW_AW-1:0]  row;
    logic [COLS-1:0][LANE_W-1:0]  lane;
  } col_map_s;
  typedef struct packed {
    logic [COLS-1:0]              en;
    logic [COLS-1:0][ROW_AW-1:0]  row;
    logic [COLS-1:0][COL_W-1:0]   data;
  } wb_entry_s;
endpackage

// ---- rtl/column_ram.sv ----
// One 16-bit column of one memory block.
// Single port: a read or a write per cycle, chosen by the caller.
`timescale 1ns/1ps
`default_nettype none
module column_ram
  import imem_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              we_i,
  input  wire logic [ROW_AW-1:0] addr_i,
  input  wire logic [COL_W-1:0]  wdata_i,
  output logic      [COL_W-1:0]  rdata_o
);
  // Content undefined after power-up, so no reset
  logic [COL_W-1:0] mem_reg [0:(1<<ROW_AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_reg[addr_i];
endmodule // column_ram
`default_nettype wire

// ---- rtl/shadow_write_buffer.sv ----
// Two-deep write buffer of one block, with per-column read forwarding.
// Retire data is written only in cycles with read_i low; the buffer holds it otherwise.
`timescale 1ns/1ps
`default_nettype none
module shadow_write_buffer
  import imem_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        write_i,
  input  wire logic                        read_i,
  input  wire wb_entry_s                   entry_i,
  input  wire logic [COLS-1:0][ROW_AW-1:0] qrow_i,
  output wb_entry_s                        retire_o,
  output logic [COLS-1:0]                  hit_o,
  output logic [COLS-1:0][COL_W-1:0]       fwd_o
);
  typedef struct packed {
    logic [1:0]                 count;
    wb_entry_s [WB_DEPTH-1:0]   ent;
  } wb_state_s;

  wb_state_s s_reg, s_next;
  logic      pop;

  always_comb begin
    pop      = (s_reg.count != 2'h0) && !read_i;
    s_next   = s_reg;
    retire_o = s_reg.ent[0];
    if (!pop) begin
      retire_o.en = '0;
    end
    if (pop) begin
      s_next.ent[0] = s_reg.ent[1];
      s_next.count  = s_reg.count - 2'h1;
    end
    if (write_i) begin
      s_next.ent[s_next.count[0]] = entry_i;
      s_next.count = s_next.count + 2'h1;
    end
    for (int c = 0; c < COLS; c++) begin
      hit_o[c] = 1'b0;
      fwd_o[c] = '0;
      // Newest entry wins so aliased overlaps read back correctly
      if (s_reg.count == 2'h2 && s_reg.ent[1].en[c] &&
          s_reg.ent[1].row[c] == qrow_i[c]) begin
        hit_o[c] = 1'b1;
        fwd_o[c] = s_reg.ent[1].data[c];
      end else if (s_reg.count != 2'h0 && s_reg.ent[0].en[c] &&
                   s_reg.ent[0].row[c] == qrow_i[c]) begin
        hit_o[c] = 1'b1;
        fwd_o[c] = s_reg.ent[0].data[c];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // shadow_write_buffer
`default_nettype wire

// ---- rtl/imem_interface.sv ----
// Internal memory interface: address aliasing, block arbitration,
// per-block shadow write buffers over four single-ported blocks.
// Assumes requesters hold no more than one request each in flight.
`timescale 1ns/1ps
`default_nettype none
module imem_interface
  import imem_pkg::*;
(
  input  wire logic                         sys_clk_i,
  input  wire logic                         reset_n_i,
  input  wire logic [REQS-1:0]              req_i,
  input  wire logic [REQS-1:0]              write_i,
  input  wire logic [REQS-1:0][1:0]         kind_i,
  input  wire logic [REQS-1:0][ADDR_W-1:0]  addr_i,
  input  wire logic [REQS-1:0][BLK_W-1:0]   block_i,
  input  wire logic [REQS-1:0][DATA_W-1:0]  wdata_i,
  input  wire logic                         fetch_miss_i,
  input  wire logic [ADDR_W-1:0]            fetch_addr_i,
  input  wire logic [BLK_W-1:0]             fetch_block_i,
  input  wire logic [BLOCKS-1:0]            block_data_width_select_i,
  output logic      [REQS-1:0]              busy_o,
  output logic      [REQS-1:0]              done_o,
  output logic      [REQS-1:0]              stall_o,
  output logic      [REQS-1:0][DATA_W-1:0]  rdata_o,
  output logic                              instr_valid_o,
  output logic      [FETCH_W-1:0]           instr_data_o
);
  typedef struct packed {
    logic [REQS-1:0]               pend;
    logic [REQS-1:0]               write;
    access_kind_e [REQS-1:0]       kind;
    logic [REQS-1:0][ADDR_W-1:0]   addr;
    logic [REQS-1:0][BLK_W-1:0]    blk;
    logic [REQS-1:0][DATA_W-1:0]   wdata;
    logic                          fetch_need;
    logic                          fetch_stage;
    logic [ADDR_W-1:0]             fetch_addr;
    logic [BLK_W-1:0]              fetch_blk;
    logic [REQS-1:0]               done;
    logic [REQS-1:0]               stall;
    logic [REQS-1:0][DATA_W-1:0]   rdata;
    logic                          instr_valid;
    logic [FETCH_W-1:0]            instr_data;
  } ctl_s;

  ctl_s                            s_reg, s_next;
  logic [1:0]                      rst_sync_reg;
  logic                            rst_n;
  logic [BLOCKS-1:0]               gnt_valid;
  logic [BLOCKS-1:0][1:0]          gnt_idx;
  col_map_s [REQS-1:0]             map;
  logic [REQS-1:0]                 wide;
  logic [REQS-1:0][DATA_W-1:0]     wword;
  logic [BLOCKS-1:0][DATA_W-1:0]   blk_rword;

  // Release reset cleanly into the core clock domain
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  function automatic col_map_s map_access(input access_kind_e k,
                                          input logic [ADDR_W-1:0] a,
                                          input logic w);
    col_map_s                m;
    logic [ADDR_W+1:0]       tri_sum;
    logic [ROW_AW-1:0]       r0;
    logic [2:0]              pos;
    m       = '0;
    tri_sum = {2'h0, a} + {1'b0, a, 1'b0};
    r0      = tri_sum[ROW_AW+1:2];
    pos     = '0;
    case (k)
      SHORT_WORD_ACCESS: begin
        m.en[a[1:0]] = 1'b1;
        for (int c = 0; c < COLS; c++) begin
          m.row[c] = a[ROW_AW+1:2];
        end
      end
      LONG_WORD_ACCESS: begin
        m.en = '1;
        for (int c = 0; c < COLS; c++) begin
          m.row[c]  = a[ROW_AW-1:0];
          m.lane[c] = LANE_W'(c);
        end
      end
      default: begin
        if (k == INSTR_FETCH || w) begin
          for (int j = 0; j < TRI_COLS; j++) begin
            pos = {1'b0, tri_sum[1:0]} + 3'(j);
            m.en[pos[1:0]]   = 1'b1;
            m.row[pos[1:0]]  = pos[2] ? r0 + 16'h0001 : r0;
            m.lane[pos[1:0]] = LANE_W'(j);
          end
        end else begin
          m.en[{a[0], 1'b0}]   = 1'b1;
          m.en[{a[0], 1'b1}]   = 1'b1;
          m.lane[{a[0], 1'b1}] = 2'h1;
          for (int c = 0; c < COLS; c++) begin
            m.row[c] = a[ROW_AW:1];
          end
        end
      end
    endcase
    return m;
  endfunction

  function automatic logic [DATA_W-1:0] shape_read(input access_kind_e k,
                                                   input logic w,
                                                   input logic [DATA_W-1:0] rw);
    logic [DATA_W-1:0] d;
    d = '0;
    case (k)
      SHORT_WORD_ACCESS:  d[COL_W-1:0] = rw[COL_W-1:0];
      LONG_WORD_ACCESS:   d = rw;
      INSTR_FETCH:        d[FETCH_W-1:0] = rw[FETCH_W-1:0];
      default: begin
        if (w) begin
          d[EXT_BITS-1:0] = rw[FETCH_W-1:FETCH_W-EXT_BITS];
        end else begin
          d[NW_BITS-1:0] = rw[NW_BITS-1:0];
        end
      end
    endcase
    return d;
  endfunction

  // Fixed priority per block; lowest requester index wins
  always_comb begin
    for (int b = 0; b < BLOCKS; b++) begin
      gnt_valid[b] = 1'b0;
      gnt_idx[b]   = 2'h0;
      for (int r = REQS - 1; r >= 0; r--) begin
        if (s_reg.pend[r] && s_reg.blk[r] == BLK_W'(b)) begin
          gnt_valid[b] = 1'b1;
          gnt_idx[b]   = 2'(r);
        end
      end
    end
  end

  always_comb begin
    for (int r = 0; r < REQS; r++) begin
      wide[r] = block_data_width_select_i[s_reg.blk[r]];
      map[r]  = map_access(s_reg.kind[r], s_reg.addr[r], wide[r]);
      wword[r] = s_reg.wdata[r];
      if (s_reg.kind[r] == NORMAL_WORD_ACCESS && wide[r]) begin
        wword[r] = {{(DATA_W-FETCH_W){1'b0}},
                    s_reg.wdata[r][EXT_BITS-1:0], EXT_PAD};
      end
    end
  end

  for (genvar b = 0; b < BLOCKS; b++) begin : g_blk
    col_map_s                     bm;
    logic                         wr;
    logic                         rd;
    wb_entry_s                    push;
    wb_entry_s                    retire;
    logic [COLS-1:0]              hit;
    logic [COLS-1:0][COL_W-1:0]   fwd;
    logic [COLS-1:0][COL_W-1:0]   ram_q;
    logic [DATA_W-1:0]            rword;

    assign bm = map[gnt_idx[b]];
    assign wr = gnt_valid[b] && s_reg.write[gnt_idx[b]];
    assign rd = gnt_valid[b] && !s_reg.write[gnt_idx[b]];

    always_comb begin
      push.en  = bm.en;
      push.row = bm.row;
      rword    = '0;
      for (int c = 0; c < COLS; c++) begin
        push.data[c] = wword[gnt_idx[b]][bm.lane[c]*COL_W +: COL_W];
        if (bm.en[c]) begin
          // Buffered copy shadows a stale array word
          rword[bm.lane[c]*COL_W +: COL_W] = hit[c] ? fwd[c] : ram_q[c];
        end
      end
    end
    assign blk_rword[b] = rword;

    shadow_write_buffer u_wbuf (
      .clk_i    (sys_clk_i),
      .rst_n_i  (rst_n),
      .write_i  (wr),
      .read_i   (rd),
      .entry_i  (push),
      .qrow_i   (bm.row),
      .retire_o (retire),
      .hit_o    (hit),
      .fwd_o    (fwd)
    );

    for (genvar c = 0; c < COLS; c++) begin : g_col
      column_ram u_col (
        .clk_i   (sys_clk_i),
        .we_i    (retire.en[c]),
        .addr_i  (rd ? bm.row[c] : retire.row[c]),
        .wdata_i (retire.data[c]),
        .rdata_o (ram_q[c])
      );
    end
  end

  always_comb begin
    s_next             = s_reg;
    s_next.done        = '0;
    s_next.stall       = '0;
    s_next.instr_valid = 1'b0;
    for (int r = 0; r < REQS; r++) begin
      if (s_reg.pend[r]) begin
        if (gnt_valid[s_reg.blk[r]] && gnt_idx[s_reg.blk[r]] == 2'(r)) begin
          if (r == PROGRAM_MEMORY_BUS && s_reg.kind[r] == INSTR_FETCH) begin
            s_next.instr_valid = 1'b1;
            s_next.instr_data  = blk_rword[s_reg.blk[r]][FETCH_W-1:0];
          end
          if (r == PROGRAM_MEMORY_BUS && s_reg.fetch_need) begin
            // Displaced fetch missed the cache: refetch next cycle
            s_next.rdata[r]    = shape_read(s_reg.kind[r], wide[r],
                                            blk_rword[s_reg.blk[r]]);
            s_next.kind[r]     = INSTR_FETCH;
            s_next.addr[r]     = s_reg.fetch_addr;
            s_next.blk[r]      = s_reg.fetch_blk;
            s_next.write[r]    = 1'b0;
            s_next.fetch_need  = 1'b0;
            s_next.fetch_stage = 1'b1;
          end else begin
            s_next.pend[r] = 1'b0;
            s_next.done[r] = 1'b1;
            if (!(r == PROGRAM_MEMORY_BUS && s_reg.fetch_stage)) begin
              s_next.rdata[r] = shape_read(s_reg.kind[r], wide[r],
                                           blk_rword[s_reg.blk[r]]);
            end
            if (r == PROGRAM_MEMORY_BUS) begin
              s_next.fetch_stage = 1'b0;
            end
          end
        end else begin
          s_next.stall[r] = 1'b1;
        end
      end else if (req_i[r]) begin
        s_next.pend[r]  = 1'b1;
        s_next.kind[r]  = access_kind_e'(kind_i[r]);
        s_next.write[r] = write_i[r] && access_kind_e'(kind_i[r]) != INSTR_FETCH;
        s_next.addr[r]  = addr_i[r];
        s_next.blk[r]   = block_i[r];
        s_next.wdata[r] = wdata_i[r];
        if (r == PROGRAM_MEMORY_BUS) begin
          s_next.fetch_need  = fetch_miss_i &&
                               access_kind_e'(kind_i[r]) != INSTR_FETCH;
          s_next.fetch_stage = 1'b0;
          s_next.fetch_addr  = fetch_addr_i;
          s_next.fetch_blk   = fetch_block_i;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_o        = s_reg.pend;
  assign done_o        = s_reg.done;
  assign stall_o       = s_reg.stall;
  assign rdata_o       = s_reg.rdata;
  assign instr_valid_o = s_reg.instr_valid;
  assign instr_data_o  = s_reg.instr_data;
endmodule // imem_interface
`default_nettype wire

// ---- dv/imem_interface_sva.sv ----
// Port checker for imem_interface arbitration and handshakes.
// Assumes requests start only after the internal reset has cleared.
`timescale 1ns/1ps
`default_nettype none
module imem_interface_sva
  import imem_pkg::*;
(
  input wire logic                       sys_clk_i,
  input wire logic                       reset_n_i,
  input wire logic [REQS-1:0]            req_i,
  input wire logic [REQS-1:0][BLK_W-1:0] block_i,
  input wire logic [REQS-1:0]            busy_o,
  input wire logic [REQS-1:0]            done_o,
  input wire logic [REQS-1:0]            stall_o,
  input wire logic                       instr_valid_o
);
  logic [REQS-1:0][BLK_W-1:0] blk_reg;
  logic [REQS-1:0]            take;
  assign take = req_i & ~busy_o;
  // Block of each taken request, kept until the next take
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blk_reg <= '0;
    end else begin
      for (int r = 0; r < REQS; r++) begin
        if (take[r]) begin
          blk_reg[r] <= block_i[r];
        end
      end
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_io_never_stalls: assert property (!stall_o[0])
    else $error("primary io bus stalled");
  // Taken at one edge, granted in the next cycle, done seen two edges on
  a_io_fixed_lat: assert property (take[0] |-> ##2 (done_o[0] && !busy_o[0]))
    else $error("primary io bus latency wrong");
  a_sec_io_second: assert property (stall_o[1] |-> done_o[0] && blk_reg[0] == blk_reg[1])
    else $error("secondary io lost without winner");
  a_data_after_io: assert property (stall_o[2] |-> (done_o[0] && blk_reg[0] == blk_reg[2])
    || (done_o[1] && blk_reg[1] == blk_reg[2]))
    else $error("data bus lost without io winner");
  a_prog_after_data: assert property (stall_o[3] |-> (done_o[0] && blk_reg[0] == blk_reg[3])
    || (done_o[1] && blk_reg[1] == blk_reg[3]) || (done_o[2] && blk_reg[2] == blk_reg[3]))
    else $error("program bus lost without winner");
  a_one_grant_block: assert property (!(done_o[0] && done_o[1] && blk_reg[0] == blk_reg[1])
    && !(done_o[0] && done_o[2] && blk_reg[0] == blk_reg[2])
    && !(done_o[1] && done_o[2] && blk_reg[1] == blk_reg[2]))
    else $error("two grants to one block");
  a_stall_keeps_busy: assert property ((stall_o & ~busy_o) == '0)
    else $error("stall without pending request");
  a_done_ends_busy: assert property (done_o != '0 |-> (done_o & busy_o) == '0
    && (done_o & ~$past(busy_o)) == '0)
    else $error("done not ending a pending request");
  a_fetch_with_done: assert property (instr_valid_o |-> done_o[3])
    else $error("fetch valid without program done");
endmodule // imem_interface_sva
bind imem_interface imem_interface_sva imem_interface_sva_inst (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .block_i(block_i),
  .busy_o(busy_o), .done_o(done_o), .stall_o(stall_o), .instr_valid_o(instr_valid_o));
`default_nettype wire

// ---- dv/requester_model.sv ----
// Requester side: two io buses, data bus and program bus.
// Assumes the bench stages lanes with set, then launches them with fire.
`timescale 1ns/1ps
`default_nettype none
module requester_model
  import imem_pkg::*;
(
  input  wire logic                       clk_i,
  output var logic [REQS-1:0]             req_o,
  output var logic [REQS-1:0]             write_o,
  output var logic [REQS-1:0][1:0]        kind_o,
  output var logic [REQS-1:0][ADDR_W-1:0] addr_o,
  output var logic [REQS-1:0][BLK_W-1:0]  block_o,
  output var logic [REQS-1:0][DATA_W-1:0] wdata_o
);
  int cyc = 0;
  int last_io = -8;
  always @(posedge clk_i) cyc <= cyc + 1;
  initial begin
    {req_o, write_o, kind_o} = '0;
    {addr_o, block_o, wdata_o} = '0;
  end
  task automatic set(input int r, w, kd, a, b, input logic [DATA_W-1:0] v);
    write_o[r] = w[0];
    kind_o[r] = kd[1:0];
    addr_o[r] = a[ADDR_W-1:0];
    block_o[r] = b[BLK_W-1:0];
    wdata_o[r] = v;
  endtask
  task automatic fire(input logic [REQS-1:0] m, output int t);
    @(negedge clk_i);
    while (m[1:0] != 2'b00 && cyc - last_io < 2) @(negedge clk_i);
    req_o = m;
    t = cyc;
    if (m[1:0] != 2'b00) last_io = cyc;
    @(negedge clk_i);
    req_o = '0;
    // Released lines must not keep showing the old value
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
    block_o = ~block_o;
  endtask
endmodule // requester_model
`default_nettype wire

// ---- dv/test_internal_memory_block_interface.sv ----
// Self-checking bench for imem_interface with a column memory model.
// Assumes one requester model drives all four request lanes.
`timescale 1ns/1ps
`default_nettype none
module test_internal_memory_block_interface
  import imem_pkg::*;
;
  localparam int LAT = 1;
  localparam logic [3:0][7:0] CB = {8'h44, 8'ha4, 8'he4, 8'h00};
  localparam logic [3:0][15:0] EX = {16'h1100, 16'h1000, 16'h0000, 16'h3210};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic miss = 1'b0;
  logic [ADDR_W-1:0] faddr = '0;
  logic [BLK_W-1:0] fblk = '0;
  logic [BLOCKS-1:0] wsel = '0;
  logic [REQS-1:0] req, wr, busy, done, stall;
  logic [REQS-1:0][1:0] kind;
  logic [REQS-1:0][ADDR_W-1:0] addr;
  logic [REQS-1:0][BLK_W-1:0] blk;
  logic [REQS-1:0][DATA_W-1:0] wdata, rdata, exp_q;
  logic ivalid;
  logic [FETCH_W-1:0] idata;
  logic [15:0] mem [int];
  int n_mismatch = 0;
  int num_checks = 0;
  int lat [REQS];
  always #10 clk = ~clk;
  requester_model requester_model_inst (.clk_i(clk), .req_o(req), .write_o(wr), .kind_o(kind),
    .addr_o(addr), .block_o(blk), .wdata_o(wdata));
  imem_interface imem_interface_inst (.sys_clk_i(clk), .reset_n_i(rst_n), .req_i(req),
    .write_i(wr), .kind_i(kind), .addr_i(addr), .block_i(blk), .wdata_i(wdata),
    .fetch_miss_i(miss), .fetch_addr_i(faddr), .fetch_block_i(fblk),
    .block_data_width_select_i(wsel), .busy_o(busy), .done_o(done), .stall_o(stall),
    .rdata_o(rdata), .instr_valid_o(ivalid), .instr_data_o(idata));
  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    num_checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic void loc(input int kd, a, k, output int c, row);
    int s;
    s = 3 * a;
    case (kd)
      0: begin c = a % 4; row = a / 4; end
      1: begin c = 2 * (a % 2) + k; row = a / 2; end
      2: begin c = k; row = a; end
      default: begin c = (s % 4 + k) % 4; row = s / 4 + (s % 4 + k >= 4); end
    endcase
  endfunction
  function automatic int amax(input int kd, b);
    return (kd == 1 && wsel[b]) ? 10 : 32 >> kd;
  endfunction
  // Stage one lane and update or consult the memory model
  task automatic prep(input int r, w, kd, a, b, input logic [63:0] v);
    int c, row, ek;
    logic [63:0] x;
    ek = (kd == 1 && wsel[b]) ? 3 : kd;
    x = (ek == 3 && kd == 1) ? {v[39:0], 8'h00} : v;
    // Reads return zero-extended data, so unused lanes expect zero
    if (!w) x = '0;
    requester_model_inst.set(r, w, kd, a, b, v);
    for (int k = 0; k < (ek == 0 ? 1 : ek == 3 ? 3 : 2 * ek); k++) begin
      loc(ek, a, k, c, row);
      if (w) mem[(b * 4 + c) * 65536 + row] = x[16*k +: 16];
      else x[16*k +: 16] = mem[(b * 4 + c) * 65536 + row];
    end
    if (!w) exp_q[r] = (ek == 3 && kd == 1) ? {24'h000000, x[47:8]} : x;
  endtask
  task automatic run(input logic [REQS-1:0] m);
    int t0, n;
    logic [REQS-1:0] seen;
    seen = '0;
    n = 0;
    requester_model_inst.fire(m, t0);
    while (seen != m && n < 20) begin
      @(negedge clk);
      n++;
      for (int r = 0; r < REQS; r++) begin
        if (m[r] && !seen[r] && done[r] === 1'b1) begin
          seen[r] = 1'b1;
          lat[r] = requester_model_inst.cyc - t0;
        end
      end
    end
    check(seen, m);
  endtask
  initial begin
    #400000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    int r, b, kd, a;
    logic [63:0] e;
    void'($urandom(85513));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (b = 0; b < 4; b++) begin
      for (a = 0; a < 8; a++) begin
        prep(2, 1, 2, a, b, {$urandom, $urandom});
        run(4'b0100);
        check(lat[2], LAT + 1);
      end
    end
    $display("test preload done");
    repeat (150) begin
      r = $urandom % 4;
      b = $urandom % 4;
      kd = $urandom % 3;
      wsel = $urandom;
      a = $urandom % amax(kd, b);
      prep(r, 1, kd, a, b, {$urandom, $urandom});
      run(4'b1 << r);
      prep(r, 0, kd, a, b, {$urandom, $urandom});
      run(4'b1 << r);
      check(rdata[r], exp_q[r]);
      kd = $urandom % 3;
      r = $urandom % 4;
      a = $urandom % amax(kd, b);
      prep(r, 0, kd, a, b, '0);
      run(4'b1 << r);
      check(rdata[r], exp_q[r]);
    end
    $display("test random alias done");
    for (a = 0; a < 10; a++) begin
      prep(3, 0, 3, a, $urandom % 4, '0);
      run(4'b1000);
      check(idata, exp_q[3]);
    end
    $display("test fetch done");
    for (int t = 0; t < 4; t++) begin
      for (r = 0; r < 4; r++) prep(r, 0, 2, $urandom % 8, CB[t][2*r +: 2], '0);
      run(4'hf);
      for (r = 0; r < 4; r++) begin
        check(lat[r], LAT + 1 + EX[t][4*r +: 4]);
        check(rdata[r], exp_q[r]);
      end
    end
    $display("test arbitration done");
    faddr = $urandom % 10;
    fblk = 2'h1;
    prep(3, 0, 3, faddr, fblk, '0);
    e = exp_q[3];
    miss = 1'b1;
    prep(3, 0, 1, $urandom % amax(1, 0), 0, '0);
    run(4'b1000);
    miss = 1'b0;
    check(lat[3], LAT + 2);
    check(rdata[3], exp_q[3]);
    check(idata, e);
    $display("test fetch miss done");
    wrap_up;
  end
endmodule // test_internal_memory_block_interface
`default_nettype wire
